// ### stack_excl_pkg.sv
// Purpose : shared types and constants for the stack and exclusive access unit
// Assumes : 16 general registers, 32-bit words, single clock
// Notes   : register indices and count, word step, status codes and register and flag reset values live here
//
// What this block does
// - push stores highest register first, highest address
// - pop loads lowest register first, lowest address
// - push decrements before, pop increments after, writeback
// - popped program counter branches halfword aligned
// - these instructions never modify condition flags
// - exclusive loads read word, byte or halfword
// - store-exclusive status: 0 stored, 1 not stored
// - success only if nobody touched the location
// - missing offset means base register is address
// - after clear-exclusive next store-exclusive fails
// - multiple transfers use consecutive 4-byte words
package stack_excl_pkg;

  // ---------------------------------------------------------------
  // register indices and sizes
  // ---------------------------------------------------------------
  localparam int          REG_COUNT   = 16;             // general registers
  localparam logic [3:0]  STACK_PTR   = 4'hD;           // stack_pointer index
  localparam logic [3:0]  LINK_REG    = 4'hE;           // link_register index
  localparam logic [3:0]  PROG_CNT    = 4'hF;           // program_counter index
  localparam logic [31:0] WORD_STEP   = 32'h0000_0004;  // bytes per word
  localparam logic [31:0] REG_RESET   = 32'h0000_0000;  // register reset value
  localparam logic [31:0] STATUS_OK   = 32'h0000_0000;  // exclusive store done
  localparam logic [31:0] STATUS_FAIL = 32'h0000_0001;  // exclusive store refused
  localparam logic [3:0]  FLAGS_RESET = 4'h0;           // nzcv after reset

  // ---------------------------------------------------------------
  // access size on the memory bus
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10
  } size_e;

  // ---------------------------------------------------------------
  // instruction selector
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_PUSH       = 4'h0,  // store_multiple_decrement_before on stack
    OP_POP        = 4'h1,  // load_multiple_increment_after on stack
    OP_LDEX_WORD  = 4'h2,  // load_exclusive_word
    OP_LDEX_BYTE  = 4'h3,  // load_exclusive_byte
    OP_LDEX_HALF  = 4'h4,  // load_exclusive_half
    OP_STEX_WORD  = 4'h5,  // store_exclusive_word
    OP_STEX_BYTE  = 4'h6,  // store_exclusive_byte
    OP_STEX_HALF  = 4'h7,  // store_exclusive_half
    OP_CLEAR_EXCL = 4'h8   // clear_exclusive
  } op_e;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    op_e         op;        // instruction
    logic [15:0] reg_set;   // register list for push/pop
    logic [3:0]  xfer_reg;  // transfer_register
    logic [3:0]  base_reg;  // base_register
    logic [3:0]  stat_reg;  // status destination
    logic        ofs_en;    // offset present
    logic [7:0]  ofs_words; // offset divided by four
  } cmd_s;

  typedef struct packed {
    logic        req;   // request pending
    logic        we;    // write when set
    size_e       size;  // access size
    logic [31:0] addr;  // byte address
    logic [31:0] wdata; // right-justified store data
  } mem_req_s;

endpackage

// ### reg_bank.sv
// Purpose : general register bank, one write port, one registered read
// Assumes : write and read of same index in one cycle returns old value
// Notes   : read data are valid one clock after the address
`timescale 1ns/1ps
module reg_bank
  import stack_excl_pkg::*;
#(
  parameter int DEPTH = REG_COUNT,  // number of registers
  parameter int WIDTH = 32          // register width
) (
  input  wire logic                     i_clk,   // core clock
  input  wire logic                     i_rst_b, // async reset, low
  input  wire logic                     i_we,    // write strobe
  input  wire logic [$clog2(DEPTH)-1:0] i_waddr, // write index
  input  wire logic [WIDTH-1:0]         i_wdata, // write data
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr, // read index
  output logic      [WIDTH-1:0]         o_rdata  // registered read data
);

  logic [WIDTH-1:0] mem_q [DEPTH]; // storage

  // ---------------------------------------------------------------
  // storage and read register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= REG_RESET;
      end
      o_rdata <= REG_RESET;
    end else begin
      if (i_we) begin
        mem_q[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_q[i_raddr];
    end
  end

endmodule

// ### stack_excl_unit.sv
// Purpose : executes push, pop, exclusive load/store and clear-exclusive
// Assumes : memory bus and snoop port run on I_CLK; one command at a time
// Notes   : stores are issued one register per bus handshake (word, or byte/halfword for exclusive), no buffering
`timescale 1ns/1ps
module stack_excl_unit
  import stack_excl_pkg::*;
(
  input  wire logic        I_CLK,        // core clock, 50 MHz
  input  wire logic        I_RST_B,      // async reset, low
  input  wire logic        I_CMD_VALID,  // command offered
  input  wire cmd_s        I_CMD,        // command fields
  output logic             O_CMD_READY,  // unit idle, takes command
  output logic             O_DONE,       // one-cycle completion pulse
  input  wire logic        I_REG_WE,     // core register write, idle only
  input  wire logic [3:0]  I_REG_IDX,    // core write index
  input  wire logic [31:0] I_REG_DATA,   // core write data
  input  wire logic        I_FLAGS_WE,   // core flag update, idle only
  input  wire logic [3:0]  I_FLAGS,      // new nzcv
  output logic      [3:0]  O_FLAGS,      // current nzcv
  output mem_req_s         O_MEM,        // memory request, held to ack
  input  wire logic        I_MEM_ACK,    // memory handshake done
  input  wire logic [31:0] I_MEM_RDATA,  // right-justified read data
  input  wire logic        I_SNOOP_VALID,// other master accessed memory
  input  wire logic [31:0] I_SNOOP_ADDR, // address of that access
  output logic             O_WB_VALID,   // register written this cycle-1
  output logic      [3:0]  O_WB_IDX,     // written index
  output logic      [31:0] O_WB_DATA,    // written value
  output logic             O_BRANCH,     // pulse: branch after pop
  output logic      [31:0] O_BRANCH_ADDR // halfword-aligned target
);

  // ---------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,  // waiting for a command
    S_BASE = 3'b001,  // base register value arrives
    S_NEXT = 3'b010,  // pick next register of the set
    S_DATA = 3'b011,  // store data arrives from the bank
    S_MEM  = 3'b100   // bus access outstanding
  } state_e;

  state_e      state_q;            // current state
  cmd_s        cmd_q;              // latched command
  logic [15:0] mask_q;             // registers still to move
  logic [31:0] addr_q;             // current access address
  logic [31:0] fin_q;              // final stack pointer value
  logic [3:0]  cur_q;              // register being moved
  logic        mon_valid_q;        // exclusive tag held
  logic [31:0] mon_addr_q;         // tagged address
  size_e       mon_size_q;         // tagged size
  logic [31:0] rdata;              // bank read data
  logic [3:0]  raddr;              // bank read index
  logic        we;                 // bank write strobe
  logic [3:0]  waddr;              // bank write index
  logic [31:0] wdata;              // bank write data
  logic        is_push;            // decoded push
  logic        is_pop;             // decoded pop
  logic        is_ldex;            // decoded exclusive load
  logic        is_stex;            // decoded exclusive store
  size_e       ex_size;            // exclusive access size
  logic [3:0]  pick;               // next register to move
  logic        ack;                // bus handshake completes

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic size_e size_of(input op_e op);
    case (op)
      OP_LDEX_BYTE, OP_STEX_BYTE: size_of = SZ_BYTE;
      OP_LDEX_HALF, OP_STEX_HALF: size_of = SZ_HALF;
      default:                    size_of = SZ_WORD;
    endcase
  endfunction

  // number of registers in a set, scaled to bytes
  function automatic logic [31:0] set_bytes(input logic [15:0] set);
    logic [31:0] n;
    n = 32'h0000_0000;
    for (int i = 0; i < REG_COUNT; i++) begin
      n = n + {28'h000_0000, 3'b000, set[i]};
    end
    set_bytes = {n[29:0], 2'b00};
  endfunction

  // highest set bit for push, lowest for pop
  function automatic logic [3:0] next_reg(input logic [15:0] set, input logic high);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (high && set[i]) begin
        r = 4'(i);
      end
      if (!high && set[REG_COUNT-1-i]) begin
        r = 4'(REG_COUNT-1-i);
      end
    end
    next_reg = r;
  endfunction

  assign is_push = (cmd_q.op == OP_PUSH);
  assign is_pop  = (cmd_q.op == OP_POP);
  assign is_ldex = (cmd_q.op == OP_LDEX_WORD) || (cmd_q.op == OP_LDEX_BYTE) || (cmd_q.op == OP_LDEX_HALF);
  assign is_stex = (cmd_q.op == OP_STEX_WORD) || (cmd_q.op == OP_STEX_BYTE) || (cmd_q.op == OP_STEX_HALF);
  assign ex_size = size_of(cmd_q.op);
  assign pick    = next_reg(mask_q, is_push);
  assign ack     = (state_q == S_MEM) && I_MEM_ACK;

  // ---------------------------------------------------------------
  // register bank ports
  // ---------------------------------------------------------------
  // read index: base first, then the register to be stored
  always_comb begin
    raddr = cmd_q.xfer_reg;
    if (state_q == S_IDLE) begin
      raddr = (I_CMD.op == OP_PUSH || I_CMD.op == OP_POP) ? STACK_PTR : I_CMD.base_reg;
    end else if (state_q == S_NEXT) begin
      raddr = pick;
    end
  end

  // write port: fsm owns it while busy, core while idle
  always_comb begin
    we    = 1'b0;
    waddr = I_REG_IDX;
    wdata = I_REG_DATA;
    if (state_q == S_IDLE) begin
      we = I_REG_WE;
    end else if (state_q == S_NEXT && mask_q == 16'h0000) begin
      we    = 1'b1;
      waddr = STACK_PTR;
      wdata = fin_q;
    end else if (state_q == S_BASE && is_stex && !(mon_valid_q && mon_size_q == ex_size &&
                 mon_addr_q == rdata + (cmd_q.ofs_en ? {22'h00_0000, cmd_q.ofs_words, 2'b00} : 32'h0000_0000))) begin
      we    = 1'b1;
      waddr = cmd_q.stat_reg;
      wdata = STATUS_FAIL;
    end else if (ack && O_MEM.we && is_stex) begin
      we    = 1'b1;
      waddr = cmd_q.stat_reg;
      wdata = STATUS_OK;
    end else if (ack && !O_MEM.we) begin
      we    = 1'b1;
      waddr = cur_q;
      case (O_MEM.size)
        SZ_BYTE: wdata = {24'h00_0000, I_MEM_RDATA[7:0]};
        SZ_HALF: wdata = {16'h0000, I_MEM_RDATA[15:0]};
        default: wdata = I_MEM_RDATA;
      endcase
    end
  end

  reg_bank #(
    .DEPTH (REG_COUNT),
    .WIDTH (32)
  ) reg_bank_inst (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_we    (we),
    .i_waddr (waddr),
    .i_wdata (wdata),
    .i_raddr (raddr),
    .o_rdata (rdata)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // one always_ff walks the command; bus request held until ack
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_q <= S_IDLE;
      cmd_q   <= '0;
      mask_q  <= 16'h0000;
      addr_q  <= 32'h0000_0000;
      fin_q   <= 32'h0000_0000;
      cur_q   <= 4'h0;
      O_MEM   <= '0;
      O_DONE  <= 1'b0;
      O_CMD_READY <= 1'b1;  // idle out of reset
    end else begin
      O_DONE <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (I_CMD_VALID) begin
            cmd_q  <= I_CMD;
            mask_q <= I_CMD.reg_set;
            cur_q  <= I_CMD.xfer_reg;
            if (I_CMD.op == OP_CLEAR_EXCL) begin
              O_DONE <= 1'b1;  // single-cycle, no bus traffic
            end else begin
              state_q <= S_BASE;
              O_CMD_READY <= 1'b0;  // busy from the next cycle
            end
          end
        end
        S_BASE: begin
          if (is_push) begin
            addr_q  <= rdata - WORD_STEP;
            fin_q   <= rdata - set_bytes(cmd_q.reg_set);
            state_q <= S_NEXT;
          end else if (is_pop) begin
            addr_q  <= rdata;
            fin_q   <= rdata + set_bytes(cmd_q.reg_set);
            state_q <= S_NEXT;
          end else begin
            // no offset: base value is the address as is
            addr_q <= rdata + (cmd_q.ofs_en ? {22'h00_0000, cmd_q.ofs_words, 2'b00} : 32'h0000_0000);
            if (is_ldex) begin
              O_MEM   <= '{req: 1'b1, we: 1'b0, size: ex_size,
                           addr: rdata + (cmd_q.ofs_en ? {22'h00_0000, cmd_q.ofs_words, 2'b00} : 32'h0000_0000),
                           wdata: 32'h0000_0000};
              state_q <= S_MEM;
            end else if (we) begin
              O_DONE  <= 1'b1;  // monitor missed, store dropped
              state_q <= S_IDLE;
              O_CMD_READY <= 1'b1;
            end else begin
              state_q <= S_DATA;  // transfer_register read under way
            end
          end
        end
        S_NEXT: begin
          if (mask_q == 16'h0000) begin
            O_DONE  <= 1'b1;
            state_q <= S_IDLE;
            O_CMD_READY <= 1'b1;
          end else begin
            cur_q            <= pick;
            mask_q[pick]     <= 1'b0;
            if (is_push) begin
              state_q <= S_DATA;
            end else begin
              O_MEM   <= '{req: 1'b1, we: 1'b0, size: SZ_WORD, addr: addr_q, wdata: 32'h0000_0000};
              state_q <= S_MEM;
            end
          end
        end
        S_DATA: begin
          O_MEM   <= '{req: 1'b1, we: 1'b1, size: size_e'(is_push ? SZ_WORD : ex_size), addr: addr_q, wdata: rdata};
          state_q <= S_MEM;
        end
        S_MEM: begin
          if (I_MEM_ACK) begin
            O_MEM.req <= 1'b0;
            if (is_push) begin
              addr_q  <= addr_q - WORD_STEP;
              state_q <= S_NEXT;
            end else if (is_pop) begin
              addr_q  <= addr_q + WORD_STEP;
              state_q <= S_NEXT;
            end else begin
              O_DONE  <= 1'b1;
              state_q <= S_IDLE;
              O_CMD_READY <= 1'b1;
            end
          end
        end
        default: begin
          state_q     <= S_IDLE;  // unknown state recovers to idle
          O_CMD_READY <= 1'b1;
        end
      endcase
    end
  end


  // ---------------------------------------------------------------
  // exclusive monitor
  // ---------------------------------------------------------------
  // a load sets the tag and wins over a snoop in the same cycle
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      mon_valid_q <= 1'b0;
      mon_addr_q  <= 32'h0000_0000;
      mon_size_q  <= SZ_WORD;
    end else begin
      if (ack && is_ldex) begin
        mon_valid_q <= 1'b1;
        mon_addr_q  <= O_MEM.addr;
        mon_size_q  <= O_MEM.size;
      end else if (state_q == S_IDLE && I_CMD_VALID && I_CMD.op == OP_CLEAR_EXCL) begin
        mon_valid_q <= 1'b0;
      end else if (state_q == S_BASE && is_stex) begin
        mon_valid_q <= 1'b0;
      end else if (I_SNOOP_VALID && I_SNOOP_ADDR[31:2] == mon_addr_q[31:2]) begin
        mon_valid_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // condition flags
  // ---------------------------------------------------------------
  // only the core updates them, and only while idle
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_FLAGS <= FLAGS_RESET;
    end else if (state_q == S_IDLE && I_FLAGS_WE) begin
      O_FLAGS <= I_FLAGS;
    end
  end

  // ---------------------------------------------------------------
  // writeback report and branch
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_WB_VALID    <= 1'b0;
      O_WB_IDX      <= 4'h0;
      O_WB_DATA     <= 32'h0000_0000;
      O_BRANCH      <= 1'b0;
      O_BRANCH_ADDR <= 32'h0000_0000;
    end else begin
      O_WB_VALID <= we && state_q != S_IDLE;
      O_WB_IDX   <= waddr;
      O_WB_DATA  <= wdata;
      O_BRANCH   <= ack && is_pop && cur_q == PROG_CNT;
      if (ack && is_pop && cur_q == PROG_CNT) begin
        O_BRANCH_ADDR <= {I_MEM_RDATA[31:1], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [3:0]  prev_reg_q;   // last register moved
  logic [31:0] prev_addr_q;  // last address used
  logic        moved_q;      // a word already moved in this command
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      prev_reg_q  <= 4'h0;
      prev_addr_q <= 32'h0000_0000;
      moved_q     <= 1'b0;
    end else if (state_q == S_IDLE) begin
      moved_q <= 1'b0;
    end else if (ack) begin
      prev_reg_q  <= cur_q;
      prev_addr_q <= O_MEM.addr;
      moved_q     <= 1'b1;
    end
  end

  property p_push_order;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (ack && is_push && moved_q) |-> (cur_q < prev_reg_q && O_MEM.addr == prev_addr_q - WORD_STEP);
  endproperty
  a_push_order: assert property (p_push_order) else $error("push order or address wrong");

  property p_pop_order;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (ack && is_pop && moved_q) |-> (cur_q > prev_reg_q && O_MEM.addr == prev_addr_q + WORD_STEP);
  endproperty
  a_pop_order: assert property (p_pop_order) else $error("pop order or address wrong");

  property p_sp_writeback;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (state_q == S_NEXT && mask_q == 16'h0000) |=> (O_WB_VALID && O_WB_IDX == STACK_PTR && O_DONE);
  endproperty
  a_sp_writeback: assert property (p_sp_writeback) else $error("stack pointer not written back");

  property p_branch_align;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (ack && is_pop && cur_q == PROG_CNT) |=> (O_BRANCH && O_BRANCH_ADDR == {$past(I_MEM_RDATA[31:1]), 1'b0});
  endproperty
  a_branch_align: assert property (p_branch_align) else $error("branch target wrong");

  property p_flags_hold;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (state_q != S_IDLE) |=> $stable(O_FLAGS);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags changed by transfer");

  property p_byte_load;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (ack && is_ldex && O_MEM.size == SZ_BYTE) |=> (O_WB_DATA[31:8] == 24'h00_0000 && O_WB_IDX == cmd_q.xfer_reg);
  endproperty
  a_byte_load: assert property (p_byte_load) else $error("byte load not zero extended");

  property p_status_ok;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (ack && is_stex) |=> (O_WB_VALID && O_WB_DATA == STATUS_OK && !mon_valid_q);
  endproperty
  a_status_ok: assert property (p_status_ok) else $error("successful store status wrong");

  property p_fail_no_store;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (state_q == S_BASE && is_stex && !mon_valid_q) |=> (O_WB_DATA == STATUS_FAIL && !O_MEM.req);
  endproperty
  a_fail_no_store: assert property (p_fail_no_store) else $error("store without monitor");

  property p_no_offset;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (state_q == S_BASE && is_ldex && !cmd_q.ofs_en) |=> (O_MEM.req && O_MEM.addr == $past(rdata));
  endproperty
  a_no_offset: assert property (p_no_offset) else $error("address not base value");

  property p_clear;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (state_q == S_IDLE && I_CMD_VALID && I_CMD.op == OP_CLEAR_EXCL) |=> (!mon_valid_q && O_DONE);
  endproperty
  a_clear: assert property (p_clear) else $error("clear left monitor set");

  property p_tag_set;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (ack && is_ldex) |=> (mon_valid_q && mon_addr_q == $past(O_MEM.addr));
  endproperty
  a_tag_set: assert property (p_tag_set) else $error("monitor tag not set");

endmodule

// ### mem_model.sv
// Purpose : behavioural system memory answering the unit's bus requests
// Assumes : 64 words at byte addresses 0x00-0xFF, right-justified lanes
// Notes   : data lines toggle when no answer is on them
`timescale 1ns/1ps
module mem_model
  import stack_excl_pkg::*;
(
  input  wire logic        i_clk,   // core clock
  input  wire logic        i_slow,  // stretch the access after each ack
  input  wire mem_req_s    i_mem,   // request from unit
  output logic             o_ack,   // one-cycle completion
  output logic      [31:0] o_rdata  // read data, valid with ack
);
  logic [31:0] mem_q [0:63];  // word store
  logic [1:0]  wait_q;        // idle cycles before ack
  logic [4:0]  sh;            // lane shift
  logic [31:0] msk;           // lane mask
  assign sh  = (i_mem.size == SZ_WORD) ? 5'h0 : {i_mem.addr[1:0], 3'h0};
  assign msk = (i_mem.size == SZ_WORD) ? 32'hFFFFFFFF : (i_mem.size == SZ_HALF) ? 32'hFFFF : 32'hFF;
  initial begin
    o_ack = 1'b0;
    o_rdata = 32'h0;
    wait_q = 2'h0;
    for (int i = 0; i < 64; i++) mem_q[i] = 32'h80706050 + i;
  end
  // ack blocks a second answer to the same held request
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_mem.req && !o_ack) begin
      if (wait_q != 2'h0) wait_q <= wait_q - 2'h1;
      else begin
        o_ack <= 1'b1;
        wait_q <= i_slow ? 2'h2 : 2'h0;
        if (i_mem.we) mem_q[i_mem.addr[7:2]] <= (mem_q[i_mem.addr[7:2]] & ~(msk << sh)) | ((i_mem.wdata & msk) << sh);
        else o_rdata <= (mem_q[i_mem.addr[7:2]] >> sh) & msk;
      end
    end
  end
endmodule

// ### stack_excl_unit_tb.sv
// Purpose : self-checking bench for stack and exclusive access unit
// Assumes : unit idle before each command; memory model on far side
// Notes   : bus addresses and register reports are logged per command
`timescale 1ns/1ps
module stack_excl_unit_tb;
  import stack_excl_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, cvalid = 1'b0, rwe = 1'b0, fwe = 1'b0, snp = 1'b0, slow = 1'b0;
  cmd_s        cmd = '0;
  logic [3:0]  ridx = 4'h0, flg = 4'h0, wbi, oflg, ilog[$];
  logic [31:0] rdat = 32'h0, saddr = 32'h0, rdata, wbd, bra, wlog[$], alog[$], blog[$];
  mem_req_s    mreq;
  logic        ready, done, ack, wbv, br, ofs = 1'b0;
  int          bad_count = 0, n_compared = 0;
  always #10 clk = ~clk;
  stack_excl_unit stack_excl_unit_inst (.I_CLK(clk), .I_RST_B(rst_b), .I_CMD_VALID(cvalid), .I_CMD(cmd),
    .O_CMD_READY(ready), .O_DONE(done), .I_REG_WE(rwe), .I_REG_IDX(ridx), .I_REG_DATA(rdat),
    .I_FLAGS_WE(fwe), .I_FLAGS(flg), .O_FLAGS(oflg), .O_MEM(mreq), .I_MEM_ACK(ack), .I_MEM_RDATA(rdata),
    .I_SNOOP_VALID(snp), .I_SNOOP_ADDR(saddr), .O_WB_VALID(wbv), .O_WB_IDX(wbi), .O_WB_DATA(wbd),
    .O_BRANCH(br), .O_BRANCH_ADDR(bra));
  mem_model mem_model_inst (.i_clk(clk), .i_slow(slow), .i_mem(mreq), .o_ack(ack), .o_rdata(rdata));
  // log bus addresses at ack, register reports and branches
  always @(posedge clk) begin
    if (mreq.req && ack) alog.push_back(mreq.addr);
    if (wbv) ilog.push_back(wbi);
    if (wbv) wlog.push_back(wbd);
    if (br) blog.push_back(bra);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // strobe held high across back-to-back writes, lowered by issue
  task automatic set_reg(input logic [3:0] i, input logic [31:0] d);
    rwe <= 1'b1;
    ridx <= i;
    rdat <= d;
    @(posedge clk);
  endtask
  // offer one command, wait its done pulse under a bound
  task automatic issue(input op_e op, input logic [15:0] set, input logic [3:0] x, b, s);
    int n;
    rwe <= 1'b0;
    cmd <= '{op, set, x, b, s, ofs, 8'h3};
    cvalid <= 1'b1;
    alog.delete();
    wlog.delete();
    ilog.delete();
    @(posedge clk);
    cvalid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 60) begin
        bad_count++;
        close_out();
      end
    end while (done !== 1'b1);
    chk({31'h0, ready}, 32'h1);
    @(negedge clk);
    @(posedge clk);
  endtask
  task automatic s_stack;
    slow <= 1'b1;
    set_reg(4'hD, 32'h100);
    set_reg(4'h1, 32'h11);
    set_reg(4'h2, 32'h22);
    set_reg(4'hE, 32'hE0F);
    issue(OP_PUSH, 16'h4006, 4'h0, 4'h0, 4'h0);
    chk(alog[0], 32'hFC);
    chk(alog[2], 32'hF4);
    chk(mem_model_inst.mem_q[63], 32'hE0F);
    chk(mem_model_inst.mem_q[61], 32'h11);
    chk(wlog[$], 32'hF4);
    chk(32'(wlog.size()), 32'h1);
    slow <= 1'b0;
    issue(OP_POP, 16'h8003, 4'h0, 4'h0, 4'h0);
    chk(alog[0], 32'hF4);
    chk(alog[2], 32'hFC);
    chk(wlog[0], 32'h11);
    chk({28'h0, ilog[1]}, 32'h1);
    chk(wlog[$], 32'h100);
    chk(blog[$], 32'hE0E);
  endtask
  task automatic s_excl;
    logic [31:0] cur, m;
    cur = 32'h80706060;
    set_reg(4'h3, 32'h40);
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'hFF : 32'hFFFF;
      set_reg(4'h5, 32'h1234ABCD + i);
      issue(op_e'(4'h2 + i), 16'h0, 4'h4, 4'h3, 4'h0);
      chk(alog[0], 32'h40);
      chk(wlog[0], cur & m);
      issue(op_e'(4'h5 + i), 16'h0, 4'h5, 4'h3, 4'h6);
      cur = (cur & ~m) | ((32'h1234ABCD + i) & m);
      chk(wlog[$], STATUS_OK);
      chk(mem_model_inst.mem_q[16], cur);
      issue(op_e'(4'h5 + i), 16'h0, 4'h5, 4'h3, 4'h6);
      chk(wlog[$], STATUS_FAIL);
      chk(32'(alog.size()), 32'h0);
    end
    ofs = 1'b1;
    issue(OP_LDEX_WORD, 16'h0, 4'h4, 4'h3, 4'h0);
    ofs = 1'b0;
    chk(alog[0], 32'h4C);
    chk(wlog[0], 32'h80706063);
    issue(OP_LDEX_WORD, 16'h0, 4'h4, 4'h3, 4'h0);
    issue(OP_CLEAR_EXCL, 16'h0, 4'h0, 4'h0, 4'h0);
    issue(OP_STEX_WORD, 16'h0, 4'h5, 4'h3, 4'h6);
    chk(wlog[$], STATUS_FAIL);
    issue(OP_LDEX_WORD, 16'h0, 4'h4, 4'h3, 4'h0);
    snp <= 1'b1;
    saddr <= 32'h42;
    @(posedge clk);
    snp <= 1'b0;
    issue(OP_STEX_WORD, 16'h0, 4'h5, 4'h3, 4'h6);
    chk(wlog[$], STATUS_FAIL);
    chk(mem_model_inst.mem_q[16], cur);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    fwe <= 1'b1;
    flg <= 4'hA;
    @(posedge clk);
    fwe <= 1'b0;
    s_stack();
    s_excl();
    chk({28'h0, oflg}, 32'hA);
    close_out();
  end
endmodule
